// ==== hw/rxoh_pkg.sv ====
package rxoh_pkg;

	// Port counts and widths
	localparam int POH_PORTS  = 16;
	localparam int STS1_COUNT = 12;
	localparam int BYTE_W     = 8;
	localparam int OW_BITS    = 24;
	localparam int LDCC_DEPTH = 8;

	// Overhead clock: 8 system cycles a period, high for the first four
	localparam logic [2:0] OH_FALL_AT   = 3'h3;
	localparam logic [2:0] OH_HIGH_CNT  = 3'h4;
	localparam logic [3:0] BYTE_LAST    = 4'h7;
	localparam logic [4:0] OW_LAST      = 5'h17;
	localparam logic [3:0] STS1_SEL_MAX = 4'hb;

	// Frame rate clock timing
	localparam int CLK_PERIOD_PS   = 4000;
	localparam int FRAME_PERIOD_NS = 125000;
	localparam int K8_HALF_CYC     =
		(FRAME_PERIOD_NS * 1000 / CLK_PERIOD_PS) / 2;

endpackage

// ==== hw/rxoh_fifo.sv ====
`timescale 1ns/1ps

module rxoh_fifo #(
	parameter int W = 8,
	parameter int D = 8
) (
	input  wire logic         clk_sys_i,   // System clock
	input  wire logic         resetn_i,    // Async reset, active low
	input  wire logic         in_valid_i,  // Write offered
	output logic              in_ready_o,  // Room for a word
	input  wire logic [W-1:0] in_data_i,   // Write word
	output logic              out_valid_o, // Word available
	input  wire logic         out_ready_i, // Drain side takes word
	output logic      [W-1:0] out_data_o   // Oldest word
);
	localparam int AW = $clog2(D);

	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [AW-1:0]       wp;
		logic [AW-1:0]       rp;
		logic [AW:0]         cnt;
		logic                rdy;
	} rxoh_fifo_st_t;

	rxoh_fifo_st_t st;
	rxoh_fifo_st_t next_st;
	logic          push;
	logic          pop;

	// ************************************************
	// Pointer and count update
	// ************************************************
	always_comb begin
		next_st = st;
		push = in_valid_i && st.rdy;
		pop  = out_ready_i && (st.cnt != '0);
		if (push) begin
			next_st.mem[st.wp] = in_data_i;
			next_st.wp = st.wp + 1'b1;
		end
		if (pop)
			next_st.rp = st.rp + 1'b1;
		next_st.cnt = st.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
		// Registered so that ready never depends on this cycle's pop
		next_st.rdy = (next_st.cnt < (AW+1)'(D));
	end

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i)
			st <= '0;
		else
			st <= next_st;
	end

	assign in_ready_o  = st.rdy;
	assign out_valid_o = (st.cnt != '0);
	assign out_data_o  = st.mem[st.rp];

endmodule // rxoh_fifo

// ==== hw/rxoh_ports.sv ====
// Behaviour
// - Serialise line DCC bytes D4..D12 out.
// - Line DCC valid high with each bit.
// - Line DCC outputs change on clock fall.
// - Order-wire strobe one period at E1 bit.
// - Serialise E1, F1, E2 on order-wire data.
// - Order-wire valid high while bytes shift.
// - Order-wire outputs change on clock fall.
// - Each path port serialises its path overhead.
// - Path ports update on own clock fall.
// - Path frame strobe marks the J1 byte.
// - Path valid high exactly with valid bits.
// - Status pin shows loss of frame normally.
// - Status pin gives 8 kHz from chosen STS-1.
// - Device makes and drives overhead clock.
`timescale 1ns/1ps

module rxoh_ports
	import rxoh_pkg::*;
#(
	parameter int K8_HALF = K8_HALF_CYC
) (
	input  wire logic                  clk_sys_i,          // 250 MHz
	input  wire logic                  resetn_i,           // Async, low
	input  wire logic                  ldcc_byte_valid_i,  // D4..D12 byte
	input  wire logic [BYTE_W-1:0]     ldcc_byte_i,        // Byte value
	output logic                       ldcc_ready_o,       // FIFO room
	input  wire logic                  ow_load_i,          // Byte trio
	input  wire logic [BYTE_W-1:0]     ow_e1_i,            // E1 byte
	input  wire logic [BYTE_W-1:0]     ow_f1_i,            // F1 byte
	input  wire logic [BYTE_W-1:0]     ow_e2_i,            // E2 byte
	input  wire logic [POH_PORTS-1:0]  poh_byte_valid_i,   // Per path
	input  wire logic [POH_PORTS-1:0][BYTE_W-1:0] poh_byte_i, // Bytes
	input  wire logic [POH_PORTS-1:0]  poh_j1_i,           // Byte is J1
	input  wire logic                  lof_i,              // LOF declared
	input  wire logic                  cfg_frame_clk_en_i, // 8 kHz mode
	input  wire logic [3:0]            sts1_sel_i,         // STS-1 pick
	input  wire logic [STS1_COUNT-1:0] sts1_frame_i,       // Frame pulses
	output logic                       overhead_port_clock_o,  // Clock
	output logic                       line_dcc_data_out_o,    // Data
	output logic                       line_dcc_valid_out_o,   // Valid
	output logic                       orderwire_frame_strobe_o, // E1
	output logic                       orderwire_data_out_o,   // Data
	output logic                       orderwire_valid_out_o,  // Valid
	output logic [POH_PORTS-1:0]       path_overhead_port_clock_o, // Clk
	output logic [POH_PORTS-1:0]       path_overhead_data_out_o,   // Data
	output logic [POH_PORTS-1:0]       path_overhead_frame_strobe_o, // J1
	output logic [POH_PORTS-1:0]       path_overhead_valid_out_o,  // Vld
	output logic                       frame_rate_clock_out_o  // LOF/8k
);

	typedef struct packed {
		logic [2:0]                        div;
		logic                              oh_clk;
		logic [BYTE_W-1:0]                 ld_sh;
		logic [3:0]                        ld_left;
		logic                              ld_dat;
		logic                              ld_val;
		logic                              ow_pend;
		logic [OW_BITS-1:0]                ow_buf;
		logic [OW_BITS-1:0]                ow_sh;
		logic [4:0]                        ow_left;
		logic                              ow_dat;
		logic                              ow_val;
		logic                              ow_fp;
		logic [POH_PORTS-1:0]              p_pend;
		logic [POH_PORTS-1:0][BYTE_W-1:0]  p_hold;
		logic [POH_PORTS-1:0]              p_hj1;
		logic [POH_PORTS-1:0][BYTE_W-1:0]  p_sh;
		logic [POH_PORTS-1:0][3:0]         p_left;
		logic [POH_PORTS-1:0]              p_dat;
		logic [POH_PORTS-1:0]              p_val;
		logic [POH_PORTS-1:0]              p_fp;
		logic [POH_PORTS-1:0]              p_clk;
		logic [13:0]                       k8_cnt;
		logic                              k8;
		logic                              stat;
	} rxoh_st_t;

	localparam logic [13:0] K8_RELOAD = 14'(K8_HALF - 1);

	rxoh_st_t          st;
	rxoh_st_t          next_st;
	logic              fall;
	logic              fifo_vld;
	logic              fifo_pop;
	logic [BYTE_W-1:0] fifo_data;

	// ************************************************
	// Line DCC byte buffer
	// ************************************************
	// Drain stalls while a byte is still shifting, so the source sees
	// back-pressure through the ready output.
	rxoh_fifo #(
		.W (BYTE_W),
		.D (LDCC_DEPTH)
	) u_ldcc_fifo (
		.clk_sys_i   (clk_sys_i),
		.resetn_i    (resetn_i),
		.in_valid_i  (ldcc_byte_valid_i),
		.in_ready_o  (ldcc_ready_o),
		.in_data_i   (ldcc_byte_i),
		.out_valid_o (fifo_vld),
		.out_ready_i (fifo_pop),
		.out_data_o  (fifo_data)
	);

	// ************************************************
	// Next state
	// ************************************************
	always_comb begin
		next_st  = st;
		fifo_pop = 1'b0;
		// Clock divider; serial outputs only move when the clock falls.
		// The clock follows the count of the cycle before, so the first
		// high phase after reset is a full four cycles like the rest.
		next_st.div    = st.div + 3'h1;
		fall           = (st.div == OH_HIGH_CNT);
		next_st.oh_clk = (st.div <= OH_FALL_AT);
		next_st.p_clk  = {POH_PORTS{next_st.oh_clk}};

		// Line DCC serialiser, MSB first
		if (fall) begin
			if (st.ld_left != 4'h0) begin
				next_st.ld_dat  = st.ld_sh[BYTE_W-1];
				next_st.ld_sh   = {st.ld_sh[BYTE_W-2:0], 1'b0};
				next_st.ld_left = st.ld_left - 4'h1;
				next_st.ld_val  = 1'b1;
			end else if (fifo_vld) begin
				fifo_pop        = 1'b1;
				next_st.ld_dat  = fifo_data[BYTE_W-1];
				next_st.ld_sh   = {fifo_data[BYTE_W-2:0], 1'b0};
				next_st.ld_left = BYTE_LAST;
				next_st.ld_val  = 1'b1;
			end else begin
				next_st.ld_dat = 1'b0;
				next_st.ld_val = 1'b0;
			end
		end

		// Order-wire serialiser: E1, F1, E2 as one 24 bit burst
		if (fall) begin
			if (st.ow_left != 5'h0) begin
				next_st.ow_dat  = st.ow_sh[OW_BITS-1];
				next_st.ow_sh   = {st.ow_sh[OW_BITS-2:0], 1'b0};
				next_st.ow_left = st.ow_left - 5'h1;
				next_st.ow_val  = 1'b1;
				next_st.ow_fp   = 1'b0;
			end else if (st.ow_pend) begin
				next_st.ow_dat  = st.ow_buf[OW_BITS-1];
				next_st.ow_sh   = {st.ow_buf[OW_BITS-2:0], 1'b0};
				next_st.ow_left = OW_LAST;
				next_st.ow_val  = 1'b1;
				next_st.ow_fp   = 1'b1;
				next_st.ow_pend = 1'b0;
			end else begin
				next_st.ow_dat = 1'b0;
				next_st.ow_val = 1'b0;
				next_st.ow_fp  = 1'b0;
			end
		end
		// A trio offered while one is still waiting is dropped; one that
		// meets the fall which frees the slot is kept (load wins)
		if (ow_load_i && !next_st.ow_pend) begin
			next_st.ow_buf  = {ow_e1_i, ow_f1_i, ow_e2_i};
			next_st.ow_pend = 1'b1;
		end

		// Path overhead serialisers, one holding byte per path
		for (int i = 0; i < POH_PORTS; i++) begin
			if (fall) begin
				if (st.p_left[i] != 4'h0) begin
					next_st.p_dat[i]  = st.p_sh[i][BYTE_W-1];
					next_st.p_sh[i]   = {st.p_sh[i][BYTE_W-2:0], 1'b0};
					next_st.p_left[i] = st.p_left[i] - 4'h1;
					next_st.p_val[i]  = 1'b1;
				end else if (st.p_pend[i]) begin
					next_st.p_dat[i]  = st.p_hold[i][BYTE_W-1];
					next_st.p_sh[i]   = {st.p_hold[i][BYTE_W-2:0], 1'b0};
					next_st.p_left[i] = BYTE_LAST;
					next_st.p_val[i]  = 1'b1;
					next_st.p_fp[i]   = st.p_hj1[i];
					next_st.p_pend[i] = 1'b0;
				end else begin
					next_st.p_dat[i] = 1'b0;
					next_st.p_val[i] = 1'b0;
					next_st.p_fp[i]  = 1'b0;
				end
			end
			// Slot freed by this fall may take a new byte at once
			if (poh_byte_valid_i[i] && !next_st.p_pend[i]) begin
				next_st.p_hold[i] = poh_byte_i[i];
				next_st.p_hj1[i]  = poh_j1_i[i];
				next_st.p_pend[i] = 1'b1;
			end
		end

		// 8 kHz: high for half a frame from each chosen frame pulse
		if (cfg_frame_clk_en_i && sts1_sel_i <= STS1_SEL_MAX
			&& sts1_frame_i[sts1_sel_i]) begin
			next_st.k8     = 1'b1;
			next_st.k8_cnt = K8_RELOAD;
		end else if (st.k8_cnt != 14'h0) begin
			next_st.k8_cnt = st.k8_cnt - 14'h1;
		end else begin
			next_st.k8 = 1'b0;
		end
		// Shared status pin, loss of frame by default
		next_st.stat = cfg_frame_clk_en_i ? next_st.k8 : lof_i;
	end

	// ************************************************
	// State register
	// ************************************************
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i)
			st <= '0;
		else
			st <= next_st;
	end

	// Every output is a state bit
	assign overhead_port_clock_o        = st.oh_clk;
	assign line_dcc_data_out_o          = st.ld_dat;
	assign line_dcc_valid_out_o         = st.ld_val;
	assign orderwire_frame_strobe_o     = st.ow_fp;
	assign orderwire_data_out_o         = st.ow_dat;
	assign orderwire_valid_out_o        = st.ow_val;
	assign path_overhead_port_clock_o   = st.p_clk;
	assign path_overhead_data_out_o     = st.p_dat;
	assign path_overhead_frame_strobe_o = st.p_fp;
	assign path_overhead_valid_out_o    = st.p_val;
	assign frame_rate_clock_out_o       = st.stat;

	// ************************************************
	// Assertions
	// ************************************************
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!resetn_i);

	sequence clk_high4;
		st.oh_clk [*4];
	endsequence
	sequence clk_low4;
		!st.oh_clk [*4];
	endsequence

	clk_shape_a: assert property ($rose(st.oh_clk) |->
		clk_high4 ##1 clk_low4 ##1 st.oh_clk)
		else $error("overhead clock not 4 high 4 low");
	ldcc_edge_a: assert property (($changed(st.ld_dat)
		|| $changed(st.ld_val)) |-> $fell(st.oh_clk))
		else $error("line dcc moved off falling edge");
	ldcc_byte_a: assert property ($rose(st.ld_val)
		|-> st.ld_val [*8])
		else $error("line dcc valid shorter than a bit");
	ldcc_src_a: assert property (fall && fifo_vld
		&& st.ld_left == 4'h0 |=> st.ld_val
		&& st.ld_dat == $past(fifo_data[BYTE_W-1]))
		else $error("line dcc byte not started");
	ow_edge_a: assert property (($changed(st.ow_dat)
		|| $changed(st.ow_fp)) |-> $fell(st.oh_clk))
		else $error("order-wire moved off falling edge");
	ow_strobe_a: assert property ($rose(st.ow_fp) |->
		(st.ow_fp && st.ow_val) [*8] ##1 !st.ow_fp)
		else $error("order-wire strobe not one period");
	ow_fp_val_a: assert property (st.ow_fp |-> st.ow_val)
		else $error("order-wire strobe without valid");
	ow_burst_a: assert property ($rose(st.ow_fp)
		|-> st.ow_val [*8] ##0 (st.ow_left == 5'h17))
		else $error("order-wire burst length wrong");
	poh_edge_a: assert property ($changed(st.p_dat[0])
		|-> $fell(st.p_clk[0]))
		else $error("path data moved off falling edge");
	poh_j1_a: assert property ($rose(st.p_fp[0])
		|-> st.p_val[0] && st.p_left[0] == BYTE_LAST)
		else $error("path strobe not on byte start");
	stat_lof_a: assert property (!cfg_frame_clk_en_i
		|=> st.stat == $past(lof_i))
		else $error("status pin not showing loss of frame");
	// Any chosen STS-1 may start the clock, not only the first one
	stat_k8_a: assert property (cfg_frame_clk_en_i
		&& sts1_sel_i <= STS1_SEL_MAX && sts1_frame_i[sts1_sel_i]
		|=> st.stat throughout (st.k8_cnt != 14'h0) [*2])
		else $error("frame rate clock not raised");

endmodule // rxoh_ports

// ==== testbench/rxoh_rx_model.sv ====
`timescale 1ns/1ps

// ****************
// Far-side capture
// ****************
module rxoh_rx_model
	import rxoh_pkg::*;
(
	input wire logic                 clk_sys_i, // System clock
	input wire logic                 oh_clk_i,  // Overhead clock
	input wire logic                 ld_dat_i,  // Line DCC data
	input wire logic                 ld_val_i,  // Line DCC valid
	input wire logic                 ow_fp_i,   // Order-wire strobe
	input wire logic                 ow_dat_i,  // Order-wire data
	input wire logic                 ow_val_i,  // Order-wire valid
	input wire logic [POH_PORTS-1:0] ph_clk_i,  // Path clocks
	input wire logic [POH_PORTS-1:0] ph_dat_i,  // Path data
	input wire logic [POH_PORTS-1:0] ph_fp_i,   // Path strobes
	input wire logic [POH_PORTS-1:0] ph_val_i   // Path valids
);
	logic [7:0]         ld_sh;
	int                 ld_bits = 0;
	logic [7:0]         ld_q[$];
	logic               ow_on = 0;
	logic [OW_BITS-1:0] ow_word;
	int                 ow_bits = 0;
	int                 ow_fp_n = 0;
	int                 ow_done = 0;
	logic [7:0]         ph_sh[POH_PORTS];
	int                 ph_bits[POH_PORTS] = '{default: 0};
	logic [7:0]         ph_last[POH_PORTS];
	int                 ph_fp_n[POH_PORTS] = '{default: 0};
	int                 ph_done[POH_PORTS] = '{default: 0};
	int                 edge_err = 0;
	logic [52:0]        prev_outs = '0;
	logic               prev_clk = 0;
	logic [52:0]        cur;

	// Outputs may move only where the clock just fell
	// Edges before the first reset edge see unknowns and are skipped
	always @(posedge clk_sys_i) begin
		cur = {ld_dat_i, ld_val_i, ow_fp_i, ow_dat_i, ow_val_i, ph_dat_i,
			ph_fp_i, ph_val_i};
		if (!$isunknown({cur, prev_outs, prev_clk, oh_clk_i})
			&& cur !== prev_outs && !(prev_clk && !oh_clk_i))
			edge_err++;
		prev_outs = cur;
		prev_clk = oh_clk_i;
	end

	// Line DCC bit taken whenever valid is seen high
	always @(posedge oh_clk_i) begin
		if (ld_val_i === 1'b1) begin
			ld_sh = {ld_sh[6:0], ld_dat_i};
			ld_bits++;
			if (ld_bits % 8 == 0)
				ld_q.push_back(ld_sh);
		end
		if (ow_fp_i === 1'b1)
			ow_fp_n++;
		// Start on valid with strobe, stop at valid low
		if (ow_val_i === 1'b1 && (ow_on || ow_fp_i === 1'b1)) begin
			ow_on = 1;
			ow_word = {ow_word[OW_BITS-2:0], ow_dat_i};
			ow_bits++;
		end else if (ow_on) begin
			ow_on = 0;
			ow_done++;
		end
	end

	// Each path port sampled on the rise of its own clock
	for (genvar i = 0; i < POH_PORTS; i++) begin : g_ph
		always @(posedge ph_clk_i[i]) begin
			if (ph_val_i[i] === 1'b1) begin
				ph_sh[i] = {ph_sh[i][6:0], ph_dat_i[i]};
				ph_bits[i]++;
				if (ph_fp_i[i] === 1'b1)
					ph_fp_n[i]++;
				if (ph_bits[i] % 8 == 0) begin
					ph_last[i] = ph_sh[i];
					ph_done[i]++;
				end
			end
		end
	end
endmodule // rxoh_rx_model

// ==== testbench/rxoh_ports_test.sv ====
`timescale 1ns/1ps

// *********
// Testbench
// *********
module rxoh_ports_test;
	import rxoh_pkg::*;
	localparam int K8 = 16; // Short 8 kHz half period keeps the run brief
	logic clk_sys_i = 0;
	logic resetn_i = 0;
	logic ld_v = 0;
	logic [7:0] ld_b = '0;
	logic ld_rdy;
	logic ow_ld = 0;
	logic [7:0] e1 = 8'ha5, f1 = 8'h3c, e2 = 8'h81;
	logic [POH_PORTS-1:0] ph_v = '0, ph_j1 = '0;
	logic [POH_PORTS-1:0][7:0] ph_b = '0;
	logic lof = 0, cfg = 0;
	logic [3:0] sel = 4'h5;
	logic [STS1_COUNT-1:0] fr = '0;
	logic oc, ld_d, ld_vo, ow_fp, ow_d, ow_vo, pin;
	logic [POH_PORTS-1:0] p_clk, p_d, p_fp, p_vo;
	int bad_count = 0;
	int compares = 0;

	// Clock
	always #2 clk_sys_i = ~clk_sys_i;

	rxoh_ports #(.K8_HALF(K8)) dut (.clk_sys_i(clk_sys_i),
		.resetn_i(resetn_i), .ldcc_byte_valid_i(ld_v), .ldcc_byte_i(ld_b),
		.ldcc_ready_o(ld_rdy), .ow_load_i(ow_ld), .ow_e1_i(e1), .ow_f1_i(f1),
		.ow_e2_i(e2), .poh_byte_valid_i(ph_v), .poh_byte_i(ph_b),
		.poh_j1_i(ph_j1), .lof_i(lof), .cfg_frame_clk_en_i(cfg),
		.sts1_sel_i(sel), .sts1_frame_i(fr), .overhead_port_clock_o(oc),
		.line_dcc_data_out_o(ld_d), .line_dcc_valid_out_o(ld_vo),
		.orderwire_frame_strobe_o(ow_fp), .orderwire_data_out_o(ow_d),
		.orderwire_valid_out_o(ow_vo), .path_overhead_port_clock_o(p_clk),
		.path_overhead_data_out_o(p_d), .path_overhead_frame_strobe_o(p_fp),
		.path_overhead_valid_out_o(p_vo), .frame_rate_clock_out_o(pin));

	rxoh_rx_model m (.clk_sys_i(clk_sys_i), .oh_clk_i(oc), .ld_dat_i(ld_d),
		.ld_val_i(ld_vo), .ow_fp_i(ow_fp), .ow_dat_i(ow_d), .ow_val_i(ow_vo),
		.ph_clk_i(p_clk), .ph_dat_i(p_d), .ph_fp_i(p_fp), .ph_val_i(p_vo));

	task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Inputs move 1 ns after the edge, clear of sampling
	task automatic step(input int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask

	task automatic t_ldcc();
		logic [7:0] exp_q[$];
		int full = 0;
		for (int k = 0; k < 10; k++) begin
			ld_v = 1;
			ld_b = 8'(k * 37) ^ 8'h3c;
			exp_q.push_back(ld_b);
			// Hold the offer until the edge that sees room
			do begin
				@(posedge clk_sys_i);
				if (ld_rdy !== 1'b1)
					full = 1;
			end while (ld_rdy !== 1'b1);
			#1;
		end
		ld_v = 0;
		step(800);
		cmp_val(full, 1);
		cmp_val(m.ld_q.size(), 10);
		foreach (exp_q[k])
			cmp_val(m.ld_q[k], exp_q[k]);
	endtask

	task automatic t_ow();
		ow_ld = 1;
		step(1);
		ow_ld = 0;
		step(240);
		cmp_val(m.ow_done, 1);
		cmp_val(m.ow_word, {e1, f1, e2});
		cmp_val(m.ow_fp_n, 1);
		cmp_val(m.ow_bits, OW_BITS);
	endtask

	task automatic t_poh();
		for (int r = 0; r < 2; r++) begin
			ph_j1 = r ? 16'haaaa : 16'h5555;
			for (int i = 0; i < POH_PORTS; i++)
				ph_b[i] = 8'(i * 17 + r) ^ 8'h5a;
			ph_v = '1;
			step(1);
			ph_v = '0;
			step(100);
			for (int i = 0; i < POH_PORTS; i++) begin
				cmp_val(m.ph_done[i], r + 1);
				cmp_val(m.ph_last[i], ph_b[i]);
				// Strobe counts add up: even ports J1 first, odd ones next
				cmp_val(m.ph_fp_n[i], 8 * ((i % 2 == 0) ? 1 : r));
			end
		end
	endtask

	task automatic t_status();
		int hi = 0;
		for (int n = 0; n < 64; n++) begin
			step(1);
			hi += oc;
			cmp_val(p_clk, {POH_PORTS{oc}});
		end
		cmp_val(hi, 32);
		lof = 1;
		step(2);
		cmp_val(pin, 1);
		lof = 0;
		step(2);
		cmp_val(pin, 0);
		cfg = 1;
		lof = 1;
		for (int c = 0; c < 2; c++) begin
			hi = 0;
			fr = c ? 12'h008 : 12'h020;
			step(1);
			fr = '0;
			// Pin rises at the edge that sees the pulse, so sample first
			for (int n = 0; n < 40; n++) begin
				hi += pin;
				step(1);
			end
			cmp_val(hi, c ? 0 : K8);
		end
	endtask

	task automatic end_sim();
		if (bad_count == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Watchdog well beyond the expected fifteen hundred cycles
	initial begin
		repeat (20000) @(posedge clk_sys_i);
		bad_count++;
		end_sim();
	end

	// Main sequence
	initial begin
		step(16);
		resetn_i = 1;
		step(2);
		t_ldcc();
		t_ow();
		t_poh();
		t_status();
		cmp_val(m.edge_err, 0);
		end_sim();
	end
endmodule // rxoh_ports_test
